// >>> hdl/gdcp_pkg.sv
// Constants, field layouts and carrier types for the gate driver control port.
package gdcp_pkg;

  // System clock rate in MHz.
  localparam int CLK_MHZ          = 100;

  // Default gap before the gate may turn on after the opposing command ends.
  localparam int DEAD_NS          = 500;
  localparam int DEAD_CYC         = (DEAD_NS * CLK_MHZ + 999) / 1000;

  // Longest silence allowed on the die-to-die heartbeat before a link fault.
  localparam int LINK_TIMEOUT_NS  = 10000;
  localparam int LINK_TIMEOUT_CYC = (LINK_TIMEOUT_NS * CLK_MHZ) / 1000;

  // APB byte offsets of the registers.
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_MASK   = 12'h008;
  localparam logic [11:0] OFF_STATE  = 12'h00C;

  // Field positions in the control register.
  localparam int CTRL_MONSEL_BIT  = 0;
  localparam int CTRL_DEAD_LSB    = 8;

  // Reset values.
  localparam logic       MONSEL_RESET = 1'b0;
  localparam logic [7:0] DEAD_RESET   = 8'(DEAD_CYC);
  localparam logic [2:0] MASK_RESET   = 3'h7;

  // Serial frame length and the addresses that a serial write may target.
  localparam int          FRAME_BITS      = 16;
  localparam logic [6:0]  SPI_ADDR_MONSEL = 7'h00;
  localparam logic [6:0]  SPI_ADDR_DEAD   = 7'h01;

  // Sticky event bits, also the layout of the mask register.
  typedef struct packed {
    logic oppConflict;
    logic frameAbort;
    logic linkFault;
  } gdcp_status_s;

  // Serial command frame, most significant bit first on the wire.
  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } gdcp_frame_s;

  // APB request from the bus master.
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } gdcp_apb_req_s;

  // APB answer of the slave.
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } gdcp_apb_rsp_s;

endpackage : gdcp_pkg

// >>> hdl/gdcp_top.sv
// Gate driver control port: serial slave, gate command logic, monitor encoder and APB registers.
//
// Notes on behaviour
// RL1 - The serial select is active low, frames each command, and serial traffic counts only while it is low.
// RL2 - The serial input is sampled on each rising serial clock edge, most significant bit first.
// RL3 - The serial output changes on the falling serial clock edge so the host can take it on the next rise.
// RL4 - Faults are reported by actively pulling the open-drain interrupt low, leaving it undriven otherwise.
// RL5 - The primary PWM input, active high, commands the gate on while high and off while low.
// RL6 - The opposing-gate command, active high, forces the gate off while high.
// RL7 - During fail-safe the gate follows the fail-safe level instead of the PWM inputs.
// RL8 - Fail-safe is entered only while the active-low fail-safe request is asserted.
// RL9 - The monitor output carries a duty-cycle-encoded temperature or voltage chosen by a serial setting.
// RL10 - The die-to-die link is watched continuously and a lost heartbeat is flagged as a fault.
// RL11 - The gate never turns on while the opposing command is high and waits a dead gap after it ends; the code lets fail-safe turn the gate on regardless.
// RL12 - A frame cut short by the select rising is discarded and leaves all settings unchanged.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module gdcp_top
#(
  parameter int MON_BITS = 8
)
(
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  input  wire gdcp_pkg::gdcp_apb_req_s apbReq,
  output var  gdcp_pkg::gdcp_apb_rsp_s apbRsp,
  input  wire logic                   serialClock,
  input  wire logic                   serialSelectN,
  input  wire logic                   serialDataIn,
  output var  logic                   serialDataOut,
  output var  logic                   serialDataOe,
  output var  logic                   faultIrqNOut,
  output var  logic                   faultIrqNOe,
  input  wire logic                   pwmIn,
  input  wire logic                   opposingGateCmd,
  input  wire logic                   failsafeRequestN,
  input  wire logic                   failsafeLevel,
  input  wire logic                   linkHeartbeat,
  input  wire logic [MON_BITS-1:0]    tempCode,
  input  wire logic [MON_BITS-1:0]    voltCode,
  output var  logic                   gateOn,
  output var  logic                   encodedMonitorOut
);

  import gdcp_pkg::*;

  localparam int PIN_COUNT  = 8;
  // Synchroniser reset levels match the idle pins, so no false select edge follows reset.
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 8'h22;
  localparam int CNT_BITS   = $clog2(FRAME_BITS + 2);
  localparam int LINK_BITS  = $clog2(LINK_TIMEOUT_CYC + 1);
  localparam logic [CNT_BITS-1:0]  FRAME_COUNT = CNT_BITS'(FRAME_BITS);
  localparam logic [CNT_BITS-1:0]  COUNT_MAX   = {CNT_BITS{1'b1}};
  localparam logic [LINK_BITS-1:0] LINK_LAST   = LINK_BITS'(LINK_TIMEOUT_CYC - 1);
  localparam logic [LINK_BITS-1:0] LINK_HIT    = LINK_BITS'(LINK_TIMEOUT_CYC - 2);

  // Decodes whether a byte address names one of the registers.
  function automatic logic isMapped(input logic [11:0] addr);
    isMapped = (addr == OFF_CTRL) || (addr == OFF_STATUS) ||
               (addr == OFF_MASK) || (addr == OFF_STATE);
  endfunction : isMapped

  // Reset release through two flip-flops.
  logic rstMeta_r;
  logic rstN_r;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstMeta_r <= 1'b0;
      rstN_r    <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstN_r    <= rstMeta_r;
    end
  end

  // Pin synchronisers, two flip-flops each; a third stage serves edge detection.
  logic [PIN_COUNT-1:0] pinRaw;
  logic [PIN_COUNT-1:0] pinMeta_r;
  logic [PIN_COUNT-1:0] pinSync_r;
  logic [PIN_COUNT-1:0] pinOld_r;

  assign pinRaw = {linkHeartbeat, failsafeLevel, failsafeRequestN, opposingGateCmd,
                   pwmIn, serialDataIn, serialSelectN, serialClock};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_sync
      always_ff @(posedge clock or negedge rstN_r)
      begin
        if (!rstN_r)
        begin
          pinMeta_r[gi] <= PIN_IDLE[gi];
          pinSync_r[gi] <= PIN_IDLE[gi];
          pinOld_r[gi]  <= PIN_IDLE[gi];
        end
        else
        begin
          pinMeta_r[gi] <= pinRaw[gi];
          pinSync_r[gi] <= pinMeta_r[gi];
          pinOld_r[gi]  <= pinSync_r[gi];
        end
      end
    end
  endgenerate

  // Named views of the synchronised pins and their edges.
  logic sclkS, selNS, mosiS, pwmS, oppS, fsReqNS, fsLevelS, beatS;
  logic sclkRise, sclkFall, selFall, selRise, beatEdge, selActive;

  assign sclkS     = pinSync_r[0];
  assign selNS     = pinSync_r[1];
  assign mosiS     = pinSync_r[2];
  assign pwmS      = pinSync_r[3];
  assign oppS      = pinSync_r[4];
  assign fsReqNS   = pinSync_r[5];
  assign fsLevelS  = pinSync_r[6];
  assign beatS     = pinSync_r[7];
  assign selActive = ~selNS & ~pinOld_r[1];                       // [RL1]
  assign sclkRise  = sclkS & ~pinOld_r[0] & selActive;            // [RL2]
  assign sclkFall  = ~sclkS & pinOld_r[0] & selActive;            // [RL3]
  assign selFall   = ~selNS & pinOld_r[1];                        // [RL1]
  assign selRise   = selNS & ~pinOld_r[1];                        // [RL1]
  assign beatEdge  = beatS ^ pinOld_r[7];

  // Register state.
  logic                  monSel_r;
  logic [7:0]            deadCycles_r;
  gdcp_status_s          status_r;
  gdcp_status_s          mask_r;
  logic [FRAME_BITS-1:0] shiftIn_r;
  logic [FRAME_BITS-1:0] shiftOut_r;
  logic [CNT_BITS-1:0]   bitCnt_r;
  logic [7:0]            deadCnt_r;
  logic [LINK_BITS-1:0]  linkCnt_r;
  logic [MON_BITS-1:0]   monCnt_r;

  // APB decode; every access answers after one wait cycle.
  logic        apbAccess, apbDone, apbWrite, wrCtrl, wrStatus, wrMask;
  logic [31:0] rdMux;

  assign apbAccess = apbReq.psel & apbReq.penable;
  assign apbDone   = apbAccess & apbRsp.pready;
  assign apbWrite  = apbDone & apbReq.pwrite & isMapped(apbReq.paddr);
  assign wrCtrl    = apbWrite & (apbReq.paddr == OFF_CTRL);
  assign wrStatus  = apbWrite & (apbReq.paddr == OFF_STATUS);
  assign wrMask    = apbWrite & (apbReq.paddr == OFF_MASK);

  // Read data selection.
  logic [31:0] ctrlWord, stateWord;

  assign ctrlWord  = {16'h0000, deadCycles_r, 7'h00, monSel_r};
  assign stateWord = {27'h0000000, faultIrqNOe, oppS, pwmS, ~fsReqNS, gateOn};
  assign rdMux     = (apbReq.paddr == OFF_CTRL)   ? ctrlWord :
                     (apbReq.paddr == OFF_STATUS) ? {29'h00000000, status_r} :
                     (apbReq.paddr == OFF_MASK)   ? {29'h00000000, mask_r} :
                     (apbReq.paddr == OFF_STATE)  ? stateWord : 32'h00000000;

  // APB answer registers.
  always_ff @(posedge clock or negedge rstN_r)
  begin
    if (!rstN_r)
      apbRsp <= '0;
    else
    begin
      apbRsp.pready  <= apbAccess & ~apbRsp.pready;
      apbRsp.pslverr <= apbAccess & ~apbRsp.pready & ~isMapped(apbReq.paddr);
      if (apbAccess & ~apbRsp.pready)
        apbRsp.prdata <= apbReq.pwrite ? 32'h00000000 : rdMux;
    end
  end

  // Serial frame decode at the select release.
  gdcp_frame_s frame;
  logic        frameDone, frameCut, spiWrMon, spiWrDead;

  assign frame     = gdcp_frame_s'(shiftIn_r);
  assign frameDone = selRise & (bitCnt_r == FRAME_COUNT);
  assign frameCut  = selRise & (bitCnt_r != FRAME_COUNT) & (bitCnt_r != '0);   // [RL12]
  assign spiWrMon  = frameDone & frame.write & (frame.addr == SPI_ADDR_MONSEL);
  assign spiWrDead = frameDone & frame.write & (frame.addr == SPI_ADDR_DEAD);

  // Serial shift registers: sample on rise, drive out on fall.
  always_ff @(posedge clock or negedge rstN_r)
  begin
    if (!rstN_r)
    begin
      shiftIn_r  <= '0;
      shiftOut_r <= '0;
      bitCnt_r   <= '0;
    end
    else if (selFall)
    begin
      bitCnt_r   <= '0;
      shiftOut_r <= {status_r, 5'h00, deadCycles_r};                         // Status bits lead.
    end
    else
    begin
      if (sclkRise)
      begin
        shiftIn_r <= {shiftIn_r[FRAME_BITS-2:0], mosiS};                      // [RL2]
        if (bitCnt_r != COUNT_MAX)
          bitCnt_r <= bitCnt_r + 1'b1;
      end
      if (sclkFall)
        shiftOut_r <= {shiftOut_r[FRAME_BITS-2:0], 1'b0};                     // [RL3]
    end
  end

  // Serial output pin: first bit at select fall, next bits on each falling edge.
  always_ff @(posedge clock or negedge rstN_r)
  begin
    if (!rstN_r)
    begin
      serialDataOut <= 1'b0;
      serialDataOe  <= 1'b0;
    end
    else
    begin
      serialDataOe <= ~selNS;                                                 // [RL1]
      if (selFall)
        serialDataOut <= status_r[2];
      else if (sclkFall)
        serialDataOut <= shiftOut_r[FRAME_BITS-2];                            // [RL3]
    end
  end

  // Settings: an APB write wins over a serial write in the same cycle.
  always_ff @(posedge clock or negedge rstN_r)
  begin
    if (!rstN_r)
    begin
      monSel_r     <= MONSEL_RESET;
      deadCycles_r <= DEAD_RESET;
      mask_r       <= gdcp_status_s'(MASK_RESET);
    end
    else
    begin
      if (wrCtrl)
      begin
        monSel_r     <= apbReq.pwdata[CTRL_MONSEL_BIT];
        deadCycles_r <= apbReq.pwdata[CTRL_DEAD_LSB +: 8];
      end
      else
      begin
        if (spiWrMon)
          monSel_r <= frame.data[0];                                          // [RL9]
        if (spiWrDead)
          deadCycles_r <= frame.data;                                         // [RL11]
      end
      if (wrMask)
        mask_r <= gdcp_status_s'(apbReq.pwdata[2:0]);
    end
  end

  // Link watchdog: counts cycles since the last heartbeat edge.
  logic linkLost;

  // Fires once per silence, so a cleared fault stays clear until the link is lost again.
  assign linkLost = ~beatEdge & (linkCnt_r == LINK_HIT);                      // [RL10]

  always_ff @(posedge clock or negedge rstN_r)
  begin
    if (!rstN_r)
      linkCnt_r <= '0;
    else if (beatEdge)
      linkCnt_r <= '0;
    else if (linkCnt_r != LINK_LAST)
      linkCnt_r <= linkCnt_r + 1'b1;                                          // [RL10]
  end

  // Sticky events; a new event wins over a write-one clear.
  gdcp_status_s evSet, status_nxt;

  assign evSet      = '{oppConflict: pwmS & oppS, frameAbort: frameCut, linkFault: linkLost};
  assign status_nxt = gdcp_status_s'((status_r & ~(wrStatus ? apbReq.pwdata[2:0] : 3'h0))
                                     | evSet);

  always_ff @(posedge clock or negedge rstN_r)
  begin
    if (!rstN_r)
      status_r <= '0;
    else
      status_r <= status_nxt;
  end

  // Open-drain interrupt: pulled low while an unmasked event is pending.
  always_ff @(posedge clock or negedge rstN_r)
  begin
    if (!rstN_r)
    begin
      faultIrqNOut <= 1'b0;
      faultIrqNOe  <= 1'b0;
    end
    else
    begin
      faultIrqNOut <= 1'b0;                                                   // [RL4]
      faultIrqNOe  <= |(status_nxt & mask_r);                                 // [RL4]
    end
  end

  // Dead gap counter reloads while the opposing command is high.
  always_ff @(posedge clock or negedge rstN_r)
  begin
    if (!rstN_r)
      deadCnt_r <= '0;
    else if (oppS)
      deadCnt_r <= deadCycles_r;                                              // [RL11]
    else if (deadCnt_r != 8'h00)
      deadCnt_r <= deadCnt_r - 1'b1;                                          // [RL11]
  end

  // Gate command selection.
  logic fsActive, gateAllow, gate_nxt;

  assign fsActive  = ~fsReqNS;                                                // [RL8]
  assign gateAllow = ~oppS & (deadCnt_r == 8'h00);                            // [RL6] [RL11]
  assign gate_nxt  = fsActive ? fsLevelS : (pwmS & gateAllow);                // [RL5] [RL7]

  always_ff @(posedge clock or negedge rstN_r)
  begin
    if (!rstN_r)
      gateOn <= 1'b0;
    else
      gateOn <= gate_nxt;                                                     // [RL5]
  end

  // Monitor encoder: output high for code counts out of each full period.
  logic [MON_BITS-1:0] monCode;

  assign monCode = monSel_r ? voltCode : tempCode;                            // [RL9]

  always_ff @(posedge clock or negedge rstN_r)
  begin
    if (!rstN_r)
    begin
      monCnt_r          <= '0;
      encodedMonitorOut <= 1'b0;
    end
    else
    begin
      monCnt_r          <= monCnt_r + 1'b1;
      encodedMonitorOut <= (monCnt_r < monCode);                              // [RL9]
    end
  end

endmodule : gdcp_top

`default_nettype wire

// >>> verif/gdcp_properties.sv
// Checker of gate, serial and interrupt pin behaviour of the control port.
`timescale 1ns/1ps
`default_nettype none
module gdcp_properties
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic serialClock,
  input wire logic serialSelectN,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  input wire logic faultIrqNOut,
  input wire logic faultIrqNOe,
  input wire logic pwmIn,
  input wire logic opposingGateCmd,
  input wire logic failsafeRequestN,
  input wire logic failsafeLevel,
  input wire logic gateOn
);
  logic [8:0] onCnt_r;
  logic [8:0] onCnt_nxt;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // Counts how long the pins have asked for the gate to be on, saturating.
  assign onCnt_nxt = !(pwmIn && !opposingGateCmd && failsafeRequestN) ? 9'h000 :
                     onCnt_r + {8'h00, onCnt_r != 9'h1FF};
  // Holds the on-request count.
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      onCnt_r <= 9'h000;
    else
      onCnt_r <= onCnt_nxt;
  // The opposing command has been high for long enough to reach the gate.
  sequence s_oppHeld;
    (opposingGateCmd && failsafeRequestN)[*6];
  endsequence
  property p_irqLow; faultIrqNOe |-> !faultIrqNOut; endproperty
  a_irqLow: assert property (p_irqLow) else $error("irq pin driven high");
  property p_oppOff; s_oppHeld |-> !gateOn; endproperty
  a_oppOff: assert property (p_oppOff) else $error("gate on under opposing");
  property p_dead; s_oppHeld ##1 !opposingGateCmd |-> !gateOn[*4]; endproperty
  a_dead: assert property (p_dead) else $error("gate on inside dead gap");
  property p_pwmOff; (!pwmIn && failsafeRequestN)[*6] |-> !gateOn; endproperty
  a_pwmOff: assert property (p_pwmOff) else $error("gate on with pwm low");
  property p_pwmOn; onCnt_r >= 9'h12C |-> gateOn; endproperty
  a_pwmOn: assert property (p_pwmOn) else $error("gate off with pwm high");
  property p_fs; (!failsafeRequestN && $stable(failsafeLevel))[*6] |-> gateOn == failsafeLevel;
  endproperty
  a_fs: assert property (p_fs) else $error("gate not at failsafe level");
  property p_selIdle; serialSelectN[*6] |-> !serialDataOe; endproperty
  a_selIdle: assert property (p_selIdle) else $error("serial out driven unselected");
  property p_misoHold; (serialClock && !serialSelectN)[*6] |-> $stable(serialDataOut); endproperty
  a_misoHold: assert property (p_misoHold) else $error("serial out moved off fall");
endmodule : gdcp_properties
bind gdcp_top gdcp_properties u_props (.clock, .reset_n, .serialClock, .serialSelectN,
  .serialDataOut, .serialDataOe, .faultIrqNOut, .faultIrqNOe, .pwmIn, .opposingGateCmd,
  .failsafeRequestN, .failsafeLevel, .gateOn);
`default_nettype wire

// >>> verif/gdcp_spi_host.sv
// Serial host model that frames commands for the control port.
`timescale 1ns/1ps
`default_nettype none
module gdcp_spi_host
(
  input  wire logic clock,
  input  wire logic misoLine,
  output var  logic serialClock,
  output var  logic serialSelectN,
  output var  logic serialDataIn
);
  // The clock idles low and the select idles high between frames.
  initial {serialClock, serialSelectN, serialDataIn} = 3'b010;
  // Shifts out the top nb bits of w and returns the first reply bit.
  task automatic xfer(input logic [15:0] w, input int nb, input int half, output logic first);
    first = 1'b0;
    @(posedge clock);
    serialSelectN <= 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      serialDataIn <= w[15 - i];
      repeat (half) @(posedge clock);
      serialClock <= 1'b1;
      if (i == 0)
        first = misoLine;
      repeat (half) @(posedge clock);
      serialClock <= 1'b0;
    end
    repeat (half) @(posedge clock);
    serialSelectN <= 1'b1;
    serialDataIn <= ~serialDataIn;
    repeat (6) @(posedge clock);
  endtask : xfer
endmodule : gdcp_spi_host
`default_nettype wire

// >>> verif/gate_driver_control_port_tb_top.sv
// Self-checking bench of the gate driver control port.
`timescale 1ns/1ps
`default_nettype none
module gate_driver_control_port_tb_top;
  import gdcp_pkg::*;
  logic          clock, reset_n, serialClock, serialSelectN, serialDataIn, serialDataOut;
  logic          serialDataOe, faultIrqNOut, faultIrqNOe, pwmIn, opposingGateCmd, gateOn;
  logic          failsafeRequestN, failsafeLevel, linkHeartbeat, encodedMonitorOut, hbOn;
  logic [7:0]    tempCode, voltCode;
  logic [5:0]    hbCnt;
  gdcp_apb_req_s apbReq;
  gdcp_apb_rsp_s apbRsp;
  wire logic     misoLine;
  int            mismatches, samples_checked, seed;
  gdcp_top dut (.clock, .reset_n, .apbReq, .apbRsp, .serialClock, .serialSelectN,
    .serialDataIn, .serialDataOut, .serialDataOe, .faultIrqNOut, .faultIrqNOe, .pwmIn,
    .opposingGateCmd, .failsafeRequestN, .failsafeLevel, .linkHeartbeat, .tempCode,
    .voltCode, .gateOn, .encodedMonitorOut);
  gdcp_spi_host host (.clock, .misoLine, .serialClock, .serialSelectN, .serialDataIn);
  // The serial output floats while the port does not drive it.
  assign misoLine = serialDataOe ? serialDataOut : 1'bz;
  // Makes the 100 MHz system clock.
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Toggles the far die heartbeat every 64 cycles while it is enabled.
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      hbCnt         <= 6'h00;
      linkHeartbeat <= 1'b0;
    end
    else
    begin
      hbCnt <= hbCnt + 6'h01;
      if (hbOn && hbCnt == 6'h00)
        linkHeartbeat <= ~linkHeartbeat;
    end
  end
  task automatic finish_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic hang(input string nm);
    $display("ERROR %s expected done seen timeout", nm);
    mismatches++;
    finish_test();
  endtask : hang
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One bus transfer: setup, then access held until ready is seen.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clock);
    apbReq <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (apbRsp.pready !== 1'b1 && n < 20);
    if (n >= 20)
      hang("pready");
    q = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq <= '0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, '0, q, e);
  endtask : rd
  task automatic waitGate(input logic v, output int n);
    n = 0;
    while (gateOn !== v && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 400)
      hang("gateOn");
  endtask : waitGate
  task automatic duty(output int h);
    h = 0;
    repeat (256)
    begin
      @(posedge clock);
      h += encodedMonitorOut;
    end
  endtask : duty
  // Drives reset and works through the scenarios.
  initial
  begin
    logic [31:0] q;
    logic        e;
    logic        f;
    logic [7:0]  dg;
    int          n;
    seed = 32'h33735F8F;
    mismatches = 0;
    samples_checked = 0;
    {reset_n, pwmIn, opposingGateCmd, failsafeLevel, hbOn} = 5'h01;
    failsafeRequestN = 1'b1;
    apbReq = '0;
    tempCode = 8'($random(seed));
    voltCode = 8'($random(seed));
    dg = 8'h08 + {3'h0, 5'($random(seed))};
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (8) @(posedge clock);
    rd(OFF_CTRL, q);
    chk("ctrl", {16'h0, DEAD_RESET, 7'h0, MONSEL_RESET}, q);
    rd(OFF_MASK, q);
    chk("mask", {29'h0, MASK_RESET}, q);
    apb(1'b0, 12'h010, '0, q, e);
    chk("slverr", 32'h1, {31'h0, e});
    host.xfer({1'b1, SPI_ADDR_DEAD, dg}, 16, 8, f);
    rd(OFF_CTRL, q);
    chk("deadSpi", {16'h0, dg, 8'h0}, q);
    host.xfer({1'b1, SPI_ADDR_DEAD, 8'hFF}, 10, 8, f);
    rd(OFF_CTRL, q);
    chk("deadKept", {16'h0, dg, 8'h0}, q);
    rd(OFF_STATUS, q);
    chk("abort", 32'h2, q);
    wr(OFF_STATUS, 32'h7);
    pwmIn <= 1'b1;
    waitGate(1'b1, n);
    repeat (310) @(posedge clock);
    opposingGateCmd <= 1'b1;
    repeat (8) @(posedge clock);
    chk("oppOff", 32'h0, {31'h0, gateOn});
    opposingGateCmd <= 1'b0;
    waitGate(1'b1, n);
    chk("deadGap", 32'h1, {31'h0, n > dg && n <= dg + 8});
    host.xfer(16'h0000, 16, 8, f);
    chk("misoFirst", 32'h1, {31'h0, f});
    rd(OFF_STATUS, q);
    chk("conflict", 32'h4, q);
    wr(OFF_STATUS, 32'h7);
    pwmIn <= 1'b0;
    waitGate(1'b0, n);
    chk("pwmOff", 32'h1, {31'h0, n < 8});
    failsafeLevel <= 1'b1;
    failsafeRequestN <= 1'b0;
    waitGate(1'b1, n);
    chk("fsHigh", 32'h1, {31'h0, n < 8});
    rd(OFF_STATE, q);
    chk("stateFs", 32'h3, q);
    pwmIn <= 1'b1;
    failsafeLevel <= 1'b0;
    waitGate(1'b0, n);
    chk("fsLow", 32'h1, {31'h0, n < 8});
    failsafeRequestN <= 1'b1;
    waitGate(1'b1, n);
    chk("fsExit", 32'h1, {31'h0, n < 8});
    pwmIn <= 1'b0;
    repeat (300) @(posedge clock);
    duty(n);
    chk("dutyTemp", {24'h0, tempCode}, n);
    host.xfer({1'b1, SPI_ADDR_MONSEL, 8'h01}, 16, 8, f);
    repeat (300) @(posedge clock);
    duty(n);
    chk("dutyVolt", {24'h0, voltCode}, n);
    wr(OFF_CTRL, {16'h0, dg, 8'h00});
    rd(OFF_CTRL, q);
    chk("ctrlApb", {16'h0, dg, 8'h00}, q);
    hbOn <= 1'b0;
    repeat (1100) @(posedge clock);
    rd(OFF_STATUS, q);
    chk("linkFault", 32'h1, q);
    chk("irqOn", 32'h1, {31'h0, faultIrqNOe});
    wr(OFF_MASK, 32'h0);
    repeat (2) @(posedge clock);
    chk("irqMasked", 32'h0, {31'h0, faultIrqNOe});
    wr(OFF_STATUS, 32'h1);
    rd(OFF_STATUS, q);
    chk("cleared", 32'h0, q);
    finish_test();
  end
endmodule : gate_driver_control_port_tb_top
`default_nettype wire
